// [logic/ssp_edge.sv]
// Edge detector for the serial clock, select and clear pins.
// Assumes inputs already synchronous to CLK_IN.
`timescale 1ns/100ps
module ssp_edge
   import ssp_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic sig_in,
   output logic      rise_out,
   output logic      fall_out,
   output logic      level_out
);
   logic prev;

   always_ff @(posedge clk_in)
   begin
      // Seeded from the pin so release from reset shows no false edge
      if (!rst_n_in)
         prev <= sig_in;
      else
         prev <= sig_in;
   end

   assign rise_out  = sig_in & ~prev;
   assign fall_out  = ~sig_in & prev;
   assign level_out = prev;
endmodule

// [logic/ssp_map.svh]
// Constants for the sensor SPI slave port.
// Assumes inclusion by the package and modules; definitions only.
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_BYTE_BITS      4'h8
`define SSP_BIT_LAST       3'h7
`define SSP_CONST_BYTE     8'h9a
`define SSP_STD_RES_BITS   5'h18
`define SSP_LEG_RES_BITS   5'h10
`define SSP_RES_MSB        5'h17
`define SSP_CMD_FLAG_BIT   3'h7
`define SSP_CLEAR_MIN_NS   100
`define SSP_CLK_NS         5
`define SSP_CLEAR_CYC      ((`SSP_CLEAR_MIN_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_CFG_ADDR_LO    4'h3
`define SSP_CFG_ADDR_HI    4'h8
`endif

// [logic/ssp_pkg.sv]
// Types for the sensor SPI slave port.
// Assumes the constants header is on the include path.
`include "ssp_map.svh"
package ssp_pkg;
   typedef enum logic [1:0] {
      SSP_IDLE    = 2'b00,
      SSP_MEASURE = 2'b01,
      SSP_READOUT = 2'b11,
      SSP_CONFIG  = 2'b10
   } ssp_state_type;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic select_n;
   } ssp_link_in_type;

   typedef struct packed {
      logic miso;
      logic miso_oe;
   } ssp_link_out_type;
endpackage

// [logic/ssp_port.sv]
// Sensor SPI slave port: command shifter, readout shifter, ready flag.
// Assumes synchronous pins, CLK_IN well above the serial clock.
// Operation
// RQ1: Master keeps serial clock at or below 1 MHz.
// RQ2: Every byte takes exactly eight serial clocks, one bit each way.
// RQ3: Both data lines carry bytes most significant bit first.
// RQ4: Master changes input on falling edges; device samples on rising edges.
// RQ5: Device updates serial output while the clock is low.
// RQ6: Clock idles low; first bit valid before first rising edge.
// RQ7: Master holds select low across each whole transfer.
// RQ8: Serial output is high impedance whenever select is high.
// RQ9: Master waits 1 us after select falls before the command.
// RQ10: Select may rise mid-sequence; measurement continues unaffected.
// RQ11: Ready flag rises when the started measurement finishes.
// RQ12: Clear pulse or configuration access drops the ready flag.
// RQ13: New command before ready replaces pending one and aborts measurement.
// RQ14: While ready, commands ignored until result bits shifted or clear.
// RQ15: Master pulses clear low-high-low, high at least 100 ns.
// RQ16: Clear empties command and stops measurement, keeps configuration.
// RQ17: Master leaves 10 ns between select edge and clear pulse.
// RQ18: Mode strap low picks standard set, high picks legacy set.
// RQ19: Master should read results only after ready rises.
// RQ20: Works with select tied low, framing by clock count.
// RQ21: Constant 0x9a shifted out while a command byte shifts in.
// RQ22: Standard mode shifts 24-bit result after ready.
// RQ23: Command bit 7 chooses measurement (0) or configuration access (1).
// RQ24: Bit counter resets when select rises.
// RQ25: Ready flag low from reset until first measurement completes.
`timescale 1ns/100ps
module ssp_port
   import ssp_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RST_N_IN,
   // Serial link
   input  wire logic        SCLK_IN,
   input  wire logic        MOSI_IN,
   input  wire logic        PORT_SELECT_LOW_IN,
   output logic             MISO_OUT,
   output logic             MISO_OE_OUT,
   // Handshake and strap
   input  wire logic        CLEAR_IN,
   input  wire logic        LEGACY_MODE_IN,
   output logic             RESULT_READY_FLAG_OUT,
   // Measurement engine side
   output logic             MEAS_START_OUT,
   output logic             MEAS_ABORT_OUT,
   output logic [7:0]       CMD_OUT,
   output logic             LEGACY_OUT,
   input  wire logic        MEAS_DONE_IN,
   input  wire logic [23:0] MEAS_RESULT_IN,
   // Configuration access side
   output logic             CFG_ACCESS_OUT,
   output logic [7:0]       CFG_BYTE_OUT
);
   ssp_link_in_type  link;
   ssp_link_out_type next_link_out;
   ssp_state_type    state;
   logic             sclk_rise;
   logic             sclk_fall;
   logic             sel_rise;
   logic             clr_fall;
   logic             clr_level;
   logic [2:0]       bit_cnt;
   logic [7:0]       rx_shift;
   logic [23:0]      tx_shift;
   logic [4:0]       res_left;
   logic             legacy;
   logic             byte_done;
   logic [7:0]       rx_byte;
   logic [7:0]       clr_cnt;
   logic             clear_hit;
   logic [7:0]       cmd_reg;

   assign link = '{sclk: SCLK_IN, mosi: MOSI_IN, select_n: PORT_SELECT_LOW_IN};

   ssp_edge u_sclk (
      .clk_in    (CLK_IN),
      .rst_n_in  (RST_N_IN),
      .sig_in    (link.sclk),
      .rise_out  (sclk_rise),
      .fall_out  (sclk_fall),
      .level_out ()
   );

   ssp_edge u_sel (
      .clk_in    (CLK_IN),
      .rst_n_in  (RST_N_IN),
      .sig_in    (link.select_n),
      .rise_out  (sel_rise),
      .fall_out  (),
      .level_out ()
   );

   ssp_edge u_clr (
      .clk_in    (CLK_IN),
      .rst_n_in  (RST_N_IN),
      .sig_in    (CLEAR_IN),
      .rise_out  (),
      .fall_out  (clr_fall),
      .level_out (clr_level)
   );

   // A rising edge with select low is one bit; select tied low still frames
   assign byte_done = sclk_rise & ~link.select_n & (bit_cnt == `SSP_BIT_LAST); // see RQ2, RQ20
   assign rx_byte   = {rx_shift[6:0], link.mosi}; // see RQ3

   // Strap resampled on every clock after reset release
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
         legacy <= 1'b0;
      else
         legacy <= LEGACY_MODE_IN; // see RQ18
   end

   // Clear counted while high; short glitches are not a clear
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
         clr_cnt <= 8'h00;
      else if (!clr_level)
         clr_cnt <= 8'h00;
      else if (clr_cnt != 8'hff)
         clr_cnt <= clr_cnt + 8'h01;
   end
   assign clear_hit = clr_fall & (clr_cnt >= 8'(`SSP_CLEAR_CYC - 1)); // see RQ15

   // Bit counter and input shifter on rising edges
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         bit_cnt  <= 3'h0;
         rx_shift <= 8'h00;
      end
      else if (sel_rise)
         bit_cnt <= 3'h0; // see RQ24
      else if (sclk_rise && !link.select_n)
      begin
         bit_cnt  <= bit_cnt + 3'h1;
         rx_shift <= rx_byte; // see RQ4
      end
   end

   // Command handling and ready flag
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         state                 <= SSP_IDLE;
         cmd_reg               <= 8'h00;
         res_left              <= 5'h00;
         RESULT_READY_FLAG_OUT <= 1'b0; // see RQ25
         MEAS_START_OUT        <= 1'b0;
         MEAS_ABORT_OUT        <= 1'b0;
         CFG_ACCESS_OUT        <= 1'b0;
         CFG_BYTE_OUT          <= 8'h00;
      end
      else
      begin
         MEAS_START_OUT <= 1'b0;
         MEAS_ABORT_OUT <= 1'b0;
         CFG_ACCESS_OUT <= 1'b0;
         if (clear_hit)
         begin
            // Configuration held outside is untouched
            state                 <= SSP_IDLE; // see RQ16
            cmd_reg               <= 8'h00;
            RESULT_READY_FLAG_OUT <= 1'b0; // see RQ12
            MEAS_ABORT_OUT        <= (state == SSP_MEASURE);
         end
         else
         begin
            case (state)
               SSP_IDLE, SSP_MEASURE:
               begin
                  if (state == SSP_MEASURE && MEAS_DONE_IN)
                  begin
                     state                 <= SSP_READOUT;
                     res_left              <= legacy ? `SSP_LEG_RES_BITS : `SSP_STD_RES_BITS; // see RQ22, RQ14
                     RESULT_READY_FLAG_OUT <= 1'b1; // see RQ11, RQ10
                  end
                  else if (byte_done)
                  begin
                     cmd_reg <= rx_byte; // see RQ13
                     MEAS_ABORT_OUT <= (state == SSP_MEASURE);
                     if (rx_byte[`SSP_CMD_FLAG_BIT])
                        state <= SSP_CONFIG; // see RQ23
                     else
                     begin
                        state          <= SSP_MEASURE;
                        MEAS_START_OUT <= 1'b1;
                     end
                  end
               end
               SSP_READOUT:
               begin
                  // Commands ignored until the result is out
                  if (sclk_rise && !link.select_n)
                  begin
                     res_left <= res_left - 5'h01; // see RQ14
                     if (res_left == 5'h01)
                        state <= SSP_IDLE;
                  end
               end
               SSP_CONFIG:
               begin
                  // Data bytes stream until select rises; any access clears
                  if (byte_done)
                  begin
                     RESULT_READY_FLAG_OUT <= 1'b0; // see RQ12
                     CFG_ACCESS_OUT        <= 1'b1;
                     CFG_BYTE_OUT          <= rx_byte;
                  end
                  if (sel_rise)
                  begin
                     state   <= SSP_IDLE;
                     cmd_reg <= 8'h00;
                  end
               end
               default:
                  state <= SSP_IDLE;
            endcase
         end
      end
   end

   // Output shifter: loads result on done and constant on byte boundary, shifts on falling edge
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
         tx_shift <= {`SSP_CONST_BYTE, 16'h0000};
      else if (state == SSP_MEASURE && MEAS_DONE_IN && !clear_hit)
         tx_shift <= legacy ? {MEAS_RESULT_IN[15:0], 8'h00} : MEAS_RESULT_IN; // see RQ22
      else if (state != SSP_READOUT && (sel_rise || (sclk_fall && !link.select_n && bit_cnt == 3'h0)))
         tx_shift <= {`SSP_CONST_BYTE, 16'h0000}; // see RQ21
      else if (sclk_fall && !link.select_n)
         tx_shift <= {tx_shift[22:0], 1'b0}; // see RQ5, RQ3
   end

   // Driven only while selected
   always_comb
   begin
      next_link_out.miso    = tx_shift[`SSP_RES_MSB]; // see RQ6
      next_link_out.miso_oe = ~link.select_n; // see RQ8
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         MISO_OUT    <= 1'b0;
         MISO_OE_OUT <= 1'b0;
      end
      else
      begin
         MISO_OUT    <= next_link_out.miso;
         MISO_OE_OUT <= next_link_out.miso_oe;
      end
   end

   assign CMD_OUT    = cmd_reg;
   assign LEGACY_OUT = legacy;

   // Assertions
   a_miso_tristate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ8
      link.select_n |=> !MISO_OE_OUT)
      else $error("serial output driven while deselected");

   a_ready_rise: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ11
      (state == SSP_MEASURE && MEAS_DONE_IN && !clear_hit) |=> RESULT_READY_FLAG_OUT)
      else $error("ready did not rise after done");

   a_clear_drops: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ12
      clear_hit |=> !RESULT_READY_FLAG_OUT && cmd_reg == 8'h00)
      else $error("clear did not drop ready");

   a_abort_new: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ13
      (state == SSP_MEASURE && byte_done && !MEAS_DONE_IN && !clear_hit) |=> MEAS_ABORT_OUT)
      else $error("new command did not abort measurement");

   a_ignore_ready: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ14
      (state == SSP_READOUT && !clear_hit) |=> !MEAS_START_OUT)
      else $error("command taken during readout");

   a_flag_decode: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ23
      (state == SSP_IDLE && byte_done && rx_byte[`SSP_CMD_FLAG_BIT] && !clear_hit) |=> state == SSP_CONFIG && !MEAS_START_OUT)
      else $error("register flag misdecoded");

   a_count_reset: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ24
      sel_rise |=> bit_cnt == 3'h0)
      else $error("bit counter kept on select rise");

   a_const_byte: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ21
      (state == SSP_IDLE && sclk_fall && !link.select_n && bit_cnt == 3'h0 && !clear_hit) |=> tx_shift[23:16] == `SSP_CONST_BYTE)
      else $error("constant byte not loaded");

   a_no_early_ready: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see RQ25
      (state == SSP_IDLE && !RESULT_READY_FLAG_OUT && !MEAS_DONE_IN) |=> !RESULT_READY_FLAG_OUT)
      else $error("ready rose without measurement");
endmodule

// [test/ssp_host_model.sv]
// Host master model for the sensor SPI slave port.
// Assumes one clock; drives link pins by NBA at rising edges.
`timescale 1ns/100ps
module ssp_host_model
   import ssp_pkg::*;
#(
   parameter int HALF = 100
)
(
   input  wire logic       clk_in,
   input  wire logic       miso_in,
   input  wire logic       miso_oe_in,
   output ssp_link_in_type link_out,
   output logic            done_out,
   output logic [7:0]      rx_out
);
   initial
   begin
      link_out = '{sclk: 1'b0, mosi: 1'b1, select_n: 1'b1};
      done_out = 1'b0;
      rx_out   = 8'h00;
   end

   task automatic sel(input logic v);
      @(posedge clk_in);
      link_out.select_n <= v;
      // 1 us before the command byte
      repeat (v ? 10 : 200) @(posedge clk_in);
   endtask

   // HALF of 100 cycles keeps SCLK at 1 MHz
   task automatic xfer(input logic [7:0] tx);
      logic [7:0] rx;
      link_out.mosi <= tx[7];
      for (int i = 7; i >= 0; i--)
      begin
         repeat (HALF) @(posedge clk_in);
         link_out.sclk <= 1'b1;
         // Undriven line reads as unknown, so a float never matches
         rx[i] = miso_oe_in ? miso_in : 1'bx;
         repeat (HALF) @(posedge clk_in);
         link_out.sclk <= 1'b0;
         // Released line shows the inverse of the last bit
         link_out.mosi <= (i > 0) ? tx[i-1] : ~tx[0];
      end
      rx_out   <= rx;
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
   endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the sensor SPI slave port.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/100ps
module tb_top;
   import ssp_pkg::*;
   logic            clk;
   logic            rst_n;
   logic            clear;
   logic            legacy;
   logic            legacy_seen;
   logic            meas_done;
   logic [23:0]     meas_result;
   logic            miso;
   logic            miso_oe;
   logic            ready;
   logic            start;
   logic            abort;
   logic [7:0]      cmd;
   logic            cfg_access;
   logic [7:0]      cfg_byte;
   ssp_link_in_type link;
   logic            hdone;
   logic [7:0]      hrx;
   logic [23:0]     r;
   logic [7:0]      exp_q[$];
   int              fails = 0;
   int              comparisons = 0;
   int              cycles = 0;
   int              starts = 0;
   int              aborts = 0;
   int              cfgs = 0;
   int              n;

   ssp_port dut (.CLK_IN(clk), .RST_N_IN(rst_n), .SCLK_IN(link.sclk), .MOSI_IN(link.mosi),
      .PORT_SELECT_LOW_IN(link.select_n), .MISO_OUT(miso), .MISO_OE_OUT(miso_oe), .CLEAR_IN(clear),
      .LEGACY_MODE_IN(legacy), .RESULT_READY_FLAG_OUT(ready), .MEAS_START_OUT(start),
      .MEAS_ABORT_OUT(abort), .CMD_OUT(cmd), .LEGACY_OUT(legacy_seen), .MEAS_DONE_IN(meas_done),
      .MEAS_RESULT_IN(meas_result), .CFG_ACCESS_OUT(cfg_access), .CFG_BYTE_OUT(cfg_byte));

   ssp_host_model host (.clk_in(clk), .miso_in(miso), .miso_oe_in(miso_oe), .link_out(link),
      .done_out(hdone), .rx_out(hrx));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Watcher: each byte received while a note waits, against the oldest note
   always @(posedge clk)
   begin
      cycles++;
      if (start === 1'b1) starts++;
      if (abort === 1'b1) aborts++;
      if (cfg_access === 1'b1) cfgs++;
      if (hdone === 1'b1 && exp_q.size() > 0)
         check({16'h0000, hrx}, {16'h0000, exp_q.pop_front()});
      if (cycles == 60000)
      begin
         fails++;
         final_report;
      end
   end

   task automatic send(input logic [7:0] c, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(c);
   endtask

   task automatic wait_ready(input logic v);
      for (int k = 0; k < 1000 && ready !== v; k++) @(posedge clk);
      check({23'h0, ready}, {23'h0, v});
   endtask

   initial
   begin
      rst_n       <= 1'b0;
      clear       <= 1'b0;
      legacy      <= 1'b0;
      meas_done   <= 1'b0;
      meas_result <= 24'h000000;
      void'($urandom(32'h0225));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check({23'h0, ready}, 24'h0);
      check({23'h0, miso_oe}, 24'h0);
      for (int m = 0; m < 2; m++)
      begin
         legacy <= m[0];
         r = 24'($urandom);
         n = starts;
         host.sel(1'b0);
         send(8'h01, `SSP_CONST_BYTE);
         host.sel(1'b1);
         check({23'h0, miso_oe}, 24'h0);
         check(24'(starts - n), 24'h1);
         check({16'h0, cmd}, 24'h01);
         check({23'h0, legacy_seen}, {23'h0, m[0]});
         @(posedge clk);
         meas_result <= r;
         meas_done <= 1'b1;
         @(posedge clk);
         meas_done <= 1'b0;
         wait_ready(1'b1);
         host.sel(1'b0);
         // Measure commands sent as filler must be ignored
         if (m == 0) send(8'h03, r[23:16]);
         send(8'h03, r[15:8]);
         send(8'h03, r[7:0]);
         check(24'(starts - n), 24'h1);
         check({23'h0, ready}, 24'h1);
         if (m == 0)
         begin
            host.xfer(8'h83);
            // Ready drops only once a register byte moves
            check({23'h0, ready}, 24'h1);
            host.xfer(8'h64);
            wait_ready(1'b0);
            check({16'h0, cfg_byte}, 24'h64);
            check(24'(cfgs > 0), 24'h1);
         end
         else
         begin
            @(posedge clk);
            clear <= 1'b1;
            repeat (20) @(posedge clk);
            clear <= 1'b0;
            wait_ready(1'b0);
            check({16'h0, cmd}, 24'h00);
            check({16'h0, cfg_byte}, 24'h64);
         end
         host.sel(1'b1);
      end
      // Back to back commands with select held low abort the first
      legacy <= 1'b0;
      n = aborts;
      host.sel(1'b0);
      send(8'h01, `SSP_CONST_BYTE);
      send(8'h02, `SSP_CONST_BYTE);
      repeat (10) @(posedge clk);
      check(24'(aborts - n), 24'h1);
      check({16'h0, cmd}, 24'h02);
      check({23'h0, ready}, 24'h0);
      host.sel(1'b1);
      final_report;
   end
endmodule
